//--- hw/dir_ctrl.sv
`timescale 1ns/10ps
`include "dir_ctrl_consts.svh"
module dir_ctrl #(
    parameter int CLK_HZ = `CLK_HZ
) (
    input  wire logic                        ref_clk,
    input  wire logic                        resetn,
    input  wire logic                        clk_en,
    input  wire logic [`BAUD_SEL_W-1:0]      baud_sel,
    input  wire logic                        host_rxd,
    output logic                             host_txd,
    input  wire logic                        sega_rxd,
    input  wire logic                        segb_rxd,
    output dir_ctrl_pkg::seg_drive_t         sega_out,
    output dir_ctrl_pkg::seg_drive_t         segb_out,
    output logic                             busy
);
    import dir_ctrl_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Operating notes
    // - Each receive line is sampled once per enabled clock; a 1 then 0
    //   pair is taken as a start bit, and only while no window is open.
    // - The window opens on the edge after the start is seen and lasts
    //   a whole number of clocks, ten bit periods with the division
    //   rounded down, so it never runs past the stop bit.
    // - Starts that arrive inside an open window are dropped, not held;
    //   a node that answers before the stop bit ends is not served.
    // - Data is sent on one clock late, the same delay as the enable,
    //   so the first low sample of the start bit is not cut short.
    // - Host characters go out on both segments; a segment character
    //   goes to the other segment and to the host.
    // - Lines rest high; reset loads that level into every sample so a
    //   line held low at release still counts as a start.
    // - With clk_en low every register holds and the outputs follow.

    ////////////////////////////////////////////////////////////////////////
    // Line numbering inside the sampled receive vector
    localparam int LINE_HOST = 0;
    localparam int LINE_SEGA = 1;
    localparam int LINE_SEGB = 2;
    localparam int N_LINES   = 3;

    ////////////////////////////////////////////////////////////////////////
    // Baud selection to character time in clock cycles
    function automatic logic [`CNT_W-1:0] char_cycles(input logic [`BAUD_SEL_W-1:0] sel);
        int baud;
        baud = 9600;
        unique case (sel)
            4'h0: baud = 300;
            4'h1: baud = 600;
            4'h2: baud = 1200;
            4'h3: baud = 2400;
            4'h4: baud = 4800;
            4'h5: baud = 9600;
            4'h6: baud = 19200;
            4'h7: baud = 38400;
            4'h8: baud = 57600;
            4'h9: baud = 115200;
            default: baud = 9600;  // Unused codes fall back to a common rate
        endcase
        // Truncation keeps the window no longer than the stop bit
        char_cycles = `CNT_W'((CLK_HZ / baud) * `CHAR_BITS);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Priority pick of the line whose start bit opens the window;
    // host first, then segment A, then segment B, so a tie is never split
    function automatic src_t pick_source(input logic [N_LINES-1:0] starts);
        src_t src;
        src = SRC_NONE;
        if (starts[LINE_HOST]) begin
            src = SRC_HOST;
        end else if (starts[LINE_SEGA]) begin
            src = SRC_SEGA;
        end else if (starts[LINE_SEGB]) begin
            src = SRC_SEGB;
        end
        pick_source = src;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Window state and per-line views
    logic                active_ff;
    src_t                src_ff;
    logic [`CNT_W-1:0]   cnt_ff;
    logic [`CNT_W-1:0]   load_val;
    logic [N_LINES-1:0]  line_now;
    logic [N_LINES-1:0]  line_start;
    logic [N_LINES-1:0]  line_dly;
    logic                any_start;
    logic                cnt_done;

    // Gather the three receivers so the edge logic is generated once
    assign line_now[LINE_HOST] = host_rxd;
    assign line_now[LINE_SEGA] = sega_rxd;
    assign line_now[LINE_SEGB] = segb_rxd;

    ////////////////////////////////////////////////////////////////////////
    // Per-line sample; it serves both as edge history and as data delay
    generate
        for (genvar g = 0; g < N_LINES; g++) begin : g_line
            logic prev_ff;

            // Reset to idle so no false edge follows release; the same
            // copy is sent on, one clock late, lined up with the enable
            always_ff @(posedge ref_clk or negedge resetn) begin
                if (!resetn) begin
                    prev_ff <= `LINE_IDLE;
                end else if (clk_en) begin
                    prev_ff <= line_now[g];
                end
            end

            // A falling edge marks a start bit
            assign line_start[g] = prev_ff & ~line_now[g];
            // Delayed data toward the drivers
            assign line_dly[g]   = prev_ff;
        end
    endgenerate

    // Start on any line, end of the counted window, and the reload value
    assign any_start = |line_start;
    assign cnt_done  = (cnt_ff == '0);
    assign load_val  = char_cycles(baud_sel) - `CNT_W'(1);

    ////////////////////////////////////////////////////////////////////////
    // Window flag; a start is only taken while idle, so a data bit that
    // falls inside the window cannot reopen or stretch it
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            active_ff <= 1'b0;
        end else if (clk_en) begin
            if (!active_ff) begin
                if (any_start) begin
                    active_ff <= 1'b1;
                end
            end else if (cnt_done) begin
                active_ff <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Source of the open window
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            src_ff <= SRC_NONE;
        end else if (clk_en) begin
            if (!active_ff) begin
                if (any_start) begin
                    src_ff <= pick_source(line_start);
                end
            end else if (cnt_done) begin
                src_ff <= SRC_NONE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Character-time counter; loaded with one less than the window so
    // the flag stays up for exactly the counted number of clocks
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_ff <= '0;
        end else if (clk_en) begin
            if (!active_ff) begin
                if (any_start) begin
                    cnt_ff <= load_val;
                end
            end else if (!cnt_done) begin
                cnt_ff <= cnt_ff - `CNT_W'(1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Driver steering; data bits pass untouched, only one clock late,
    // so content and framing are kept
    always_comb begin
        sega_out.de  = 1'b0;
        segb_out.de  = 1'b0;
        sega_out.txd = `LINE_IDLE;
        segb_out.txd = `LINE_IDLE;
        host_txd     = `LINE_IDLE;
        unique case (src_ff)
            SRC_NONE: begin
            end
            SRC_HOST: begin
                // Host drives both segments as a converter
                sega_out.de  = active_ff;
                segb_out.de  = active_ff;
                sega_out.txd = line_dly[LINE_HOST];
                segb_out.txd = line_dly[LINE_HOST];
            end
            SRC_SEGA: begin
                // Segment A feeds segment B and the host
                segb_out.de  = active_ff;
                segb_out.txd = line_dly[LINE_SEGA];
                host_txd     = line_dly[LINE_SEGA];
            end
            SRC_SEGB: begin
                // Segment B feeds segment A and the host
                sega_out.de  = active_ff;
                sega_out.txd = line_dly[LINE_SEGB];
                host_txd     = line_dly[LINE_SEGB];
            end
        endcase
    end

    // Window flag straight from its register
    assign busy = active_ff;
endmodule

//--- hw/dir_ctrl_consts.svh
`ifndef DIR_CTRL_CONSTS_SVH
`define DIR_CTRL_CONSTS_SVH
// Clock rate in Hz
`define CLK_HZ          100000000
// Bits in one character: start, eight data, one stop
`define CHAR_BITS       10
// Width of the baud selector
`define BAUD_SEL_W      4
// Width of the character-time counter
`define CNT_W           24
// Idle line level of a UART or RS-485 receiver
`define LINE_IDLE       1'b1
`endif

//--- hw/dir_ctrl_pkg.sv
`include "dir_ctrl_consts.svh"
package dir_ctrl_pkg;
    // Which input began the current character
    typedef enum logic [1:0] {
        SRC_NONE = 2'b00,
        SRC_HOST = 2'b01,
        SRC_SEGA = 2'b10,
        SRC_SEGB = 2'b11
    } src_t;

    // Driver enables and data toward the two RS-485 segments
    typedef struct packed {
        logic de;
        logic txd;
    } seg_drive_t;
endpackage

//--- sim/far_nodes.sv
`timescale 1ns/10ps
// Host UART and two segment nodes; biased lines rest high between frames
module far_nodes (
    input  wire logic ref_clk,
    output logic [2:0] rxd
);
    initial rxd = 3'h7;
    // One frame, LSB first; there is no handshake line to drive
    task automatic send(input int idx, input logic [7:0] d, input int b);
        for (int i = 0; i < 10; i++) begin
            rxd[idx] = (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : d[i-1];
            repeat (b) @(negedge ref_clk);
        end
    endtask
endmodule

//--- sim/dir_ctrl_sva.sv
`timescale 1ns/10ps
module dir_ctrl_sva (
    input wire logic ref_clk, resetn, clk_en, host_rxd, sega_rxd, segb_rxd, host_txd, busy,
    input wire dir_ctrl_pkg::seg_drive_t sega_out, segb_out
);
    import dir_ctrl_pkg::*;
    logic [1:0] de;
    assign de = {sega_out.de, segb_out.de};
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////
    chk_idle_quiet: assert property (!busy |-> de == 2'h0) else $error("driver on");
    chk_start_seen: assert property (
        !busy && clk_en && ($fell(host_rxd) || $fell(sega_rxd) || $fell(segb_rxd)) |=> busy) else $error("missed");
    chk_min_window: assert property ($rose(busy) |-> busy[*8]) else $error("short");
    chk_de_busy: assert property (busy |-> de != 2'h0) else $error("no driver");
    chk_host_path: assert property (
        de == 2'h3 && $past(clk_en) |-> sega_out.txd == $past(host_rxd) && segb_out.txd == $past(host_rxd)
        && host_txd) else $error("host");
    chk_a_to_b: assert property (de == 2'h1 && $past(clk_en) |->
        segb_out.txd == $past(sega_rxd) && host_txd == $past(sega_rxd)) else $error("a");
    chk_b_to_a: assert property (de == 2'h2 && $past(clk_en) |->
        sega_out.txd == $past(segb_rxd) && host_txd == $past(segb_rxd)) else $error("b");
    chk_host_rest: assert property (!busy |-> host_txd) else $error("host idle");
endmodule
bind dir_ctrl dir_ctrl_sva i_sva (.ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .host_rxd(host_rxd),
    .sega_rxd(sega_rxd), .segb_rxd(segb_rxd), .host_txd(host_txd), .busy(busy), .sega_out(sega_out),
    .segb_out(segb_out));

//--- sim/dir_ctrl_bench.sv
`timescale 1ns/10ps
module half_duplex_bus_direction_control_bench;
    import dir_ctrl_pkg::*;
    int rates[11] = '{300, 600, 1200, 2400, 4800, 9600, 19200, 38400, 57600, 115200, 9600};
    logic ref_clk = 0, resetn = 0, clk_en = 1, host_txd, busy;
    logic [3:0] baud_sel = 4'h0;
    logic [2:0] rxd;
    logic [1:0] de;
    seg_drive_t sega_out, segb_out;
    int n_errors, check_count, n;
    assign de = {sega_out.de, segb_out.de};
    dir_ctrl #(.CLK_HZ(1000000)) i_dut (.ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .baud_sel(baud_sel),
        .host_rxd(rxd[0]), .host_txd(host_txd), .sega_rxd(rxd[1]), .segb_rxd(rxd[2]), .sega_out(sega_out),
        .segb_out(segb_out), .busy(busy));
    far_nodes i_far (.ref_clk(ref_clk), .rxd(rxd));
    ////////////////////////////////////////
    task automatic check(input string w, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %0d seen %0d", w, exp, seen);
        end
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Data bits fall inside the window, so a restart would show as a long window
    task automatic t_char(input int s, input int stall);
        baud_sel = 4'(s);
        fork
            i_far.send(s % 3, 8'h35, 1000000 / rates[s]);
            begin
                @(negedge ref_clk);
                check("de", de, (s % 3 == 0) ? 3 : (s % 3 == 1) ? 1 : 2);
                for (n = 0; busy && n < 40000; n++) begin
                    clk_en = !(stall && n > 0 && n < 6);
                    @(negedge ref_clk);
                end
                check("win", n, 1000000 / rates[s] * 10 + stall * 5);
                check("idle", {de, host_txd}, 1);
            end
        join
        $display("char test %0d done", s);
    endtask
    ////////////////////////////////////////
    initial forever #5 ref_clk = ~ref_clk;
    // Whole run is near 68k cycles
    initial begin
        #900000;
        n_errors++;
        summarize();
    end
    initial begin
        repeat (4) @(negedge ref_clk);
        resetn = 1;
        @(negedge ref_clk);
        check("rest", {de, host_txd, busy}, 2);
        for (int s = 0; s < 11; s++) t_char(s, s == 9);
        summarize();
    end
endmodule
